/* logic/nvm_access.sv */
// Access control for a 256-byte data nonvolatile store behind the
// core's special function registers, plus an external programming port.
// Assumes single-cycle register reads and writes from the core on SYS_CLK
// and an external port already synchronised to SYS_CLK.
//
// What this block does
// - Write allow cleared on power-up reset
// - No core write while power-up timer runs
// - Write needs 55h, AAh, then start
// - Write-start reads set during whole write
// - Unlock port has no storage, reads zero
// - Code protect blocks external port access
// - Core access ignores code protect
// - Array accessed one byte per address
// - Write start set by software, cleared hardware; read start never set, reads zero
// - Write start needs earlier write allow
// - Write end clears start, sets done flag
// - Read byte ready next cycle, held
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_regs.svh"

module nvm_access
    import nvm_access_pkg::*;
#(
    parameter int POWERUP_CYCLES = `POWERUP_CYCLES,
    parameter int WRITE_CYCLES   = `WRITE_TIME_CYCLES
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        POR_N,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        CODE_PROTECT,
    input  wire logic        EXT_RD,
    input  wire logic        EXT_WR,
    input  wire logic [7:0]  EXT_ADDR,
    input  wire logic [7:0]  EXT_WDATA,
    output logic      [7:0]  EXT_RDATA,
    output logic             EXT_DENIED,
    output logic             WRITE_DONE_IRQ
);
    localparam int HALF_CYCLES = (WRITE_CYCLES + 1) / 2;

    logic [7:0]    mem [256];         // The byte array
    logic [7:0]    addr_q;            // Byte address register
    logic [7:0]    data_q;            // Data byte register
    logic          allow_q;           // Write allow
    logic          abort_q;           // Write aborted flag
    logic [1:0]    sel_q;             // Program/config select bits
    logic          rd_go_q;           // Read start bit
    logic          wr_go_q;           // Write start bit
    logic [7:0]    ien_q;             // Interrupt enable two
    logic [7:0]    iflag_q;           // Interrupt flags two
    logic [7:0]    iprio_q;           // Interrupt priority two
    logic [7:0]    icon_q;            // Core interrupt control
    unlock_state_t unl_q;             // Unlock tracker
    write_state_t  wst_q;             // Write engine state
    logic [31:0]   wcnt_q;            // Write phase counter
    logic [31:0]   pcnt_q;            // Power-up timer
    logic          pwrt_busy;         // Power-up timer running
    logic          wr_start;          // Write accepted this cycle
    logic          wr_end;            // Write completes this cycle
    logic          ctl_wr;            // Control register written

    // Register address decode
    function automatic logic hit(input logic [11:0] off);
        return REG_WR && REG_ADDR == off;
    endfunction

    assign ctl_wr    = hit(`OFF_NVM_CONTROL);
    assign pwrt_busy = pcnt_q != 32'h0;
    // Start only when open, allowed earlier, idle, timer done
    assign wr_start  = ctl_wr && REG_WDATA[`CTL_WRITE_START_BIT] &&
                       unl_q == UNLOCK_OPEN && allow_q &&
                       !pwrt_busy && wst_q == WR_IDLE;
    assign wr_end    = wst_q == WR_PROGRAM && wcnt_q == 32'h0;

    // Power-up timer, restarted only by power-on reset
    always_ff @(posedge SYS_CLK) begin
        if (!POR_N) begin
            pcnt_q <= POWERUP_CYCLES;
        end else if (pwrt_busy) begin
            pcnt_q <= pcnt_q - 32'h1;
        end
    end

    // Unlock tracker; any other register write breaks the sequence
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            unl_q <= UNLOCK_IDLE;
        end else if (hit(`OFF_NVM_UNLOCK_PORT)) begin
            if (REG_WDATA == `UNLOCK_FIRST) begin
                unl_q <= UNLOCK_GOT1;
            end else if (REG_WDATA == `UNLOCK_SECOND &&
                         unl_q == UNLOCK_GOT1) begin
                unl_q <= UNLOCK_OPEN;
            end else begin
                unl_q <= UNLOCK_IDLE;
            end
        end else if (REG_WR) begin
            unl_q <= UNLOCK_IDLE;
        end
    end

    // Write engine: erase half, program half
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            wst_q  <= WR_IDLE;
            wcnt_q <= 32'h0;
        end else begin
            unique case (wst_q)
                WR_IDLE: begin
                    if (wr_start) begin
                        wst_q  <= WR_ERASE;
                        wcnt_q <= HALF_CYCLES - 1;
                    end
                end
                WR_ERASE: begin
                    if (wcnt_q == 32'h0) begin
                        wst_q  <= WR_PROGRAM;
                        wcnt_q <= HALF_CYCLES - 1;
                    end else begin
                        wcnt_q <= wcnt_q - 32'h1;
                    end
                end
                WR_PROGRAM: begin
                    if (wr_end) begin
                        wst_q <= WR_IDLE;
                    end else begin
                        wcnt_q <= wcnt_q - 32'h1;
                    end
                end
                default: begin
                    wst_q <= WR_IDLE;
                end
            endcase
        end
    end

    // Array: erase to FFh, then program; external port when unprotected
    always_ff @(posedge SYS_CLK) begin
        if (wst_q == WR_ERASE && wcnt_q == 32'h0) begin
            mem[addr_q] <= 8'hFF;
        end else if (wr_end) begin
            mem[addr_q] <= data_q;
        end else if (EXT_WR && !CODE_PROTECT &&
                     wst_q == WR_IDLE) begin
            mem[EXT_ADDR] <= EXT_WDATA;
        end
    end

    // External read port, blocked under code protect
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            EXT_RDATA  <= 8'h00;
            EXT_DENIED <= 1'b0;
        end else begin
            EXT_DENIED <= (EXT_RD || EXT_WR) && CODE_PROTECT;
            if (EXT_RD) begin
                EXT_RDATA <= CODE_PROTECT ? 8'h00 : mem[EXT_ADDR];
            end
        end
    end

    // Address and data registers; frozen during a write
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            addr_q <= 8'h00;
            data_q <= 8'h00;
        end else begin
            if (hit(`OFF_NVM_BYTE_ADDRESS) && wst_q == WR_IDLE) begin
                addr_q <= REG_WDATA;
            end
            if (ctl_wr && REG_WDATA[`CTL_READ_START_BIT] &&
                wst_q == WR_IDLE) begin
                data_q <= mem[addr_q];
            end else if (hit(`OFF_NVM_DATA_BYTE) && wst_q == WR_IDLE) begin
                data_q <= REG_WDATA;
            end
        end
    end

    // Control bits; write start set only, hardware clears
    always_ff @(posedge SYS_CLK) begin
        if (!POR_N) begin
            allow_q <= 1'b0;
            abort_q <= 1'b0;
            sel_q   <= 2'b00;
        end else if (!RST_N) begin
            allow_q <= 1'b0;
            abort_q <= abort_q | (wst_q != WR_IDLE);
        end else if (ctl_wr && wst_q == WR_IDLE) begin
            allow_q <= REG_WDATA[`CTL_WRITE_ALLOW_BIT];
            abort_q <= REG_WDATA[`CTL_WRITE_ABORT_BIT];
            sel_q   <= REG_WDATA[`CTL_PROG_SEL_BIT:`CTL_CONFIG_SEL_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rd_go_q <= 1'b0;
            wr_go_q <= 1'b0;
        end else begin
            // Read completes in one cycle
            rd_go_q <= 1'b0;
            if (wr_start) begin
                wr_go_q <= 1'b1;
            end else if (wr_end) begin
                wr_go_q <= 1'b0;
            end
        end
    end

    // Interrupt registers; done event beats a software clear
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ien_q   <= `RST_IRQ_ENABLE_TWO;
            iflag_q <= `RST_IRQ_FLAGS_TWO;
            iprio_q <= `RST_IRQ_PRIORITY_TWO;
            icon_q  <= 8'h00;
        end else begin
            if (hit(`OFF_IRQ_ENABLE_TWO)) ien_q <= REG_WDATA;
            if (hit(`OFF_IRQ_PRIORITY_TWO)) iprio_q <= REG_WDATA;
            if (hit(`OFF_CORE_IRQ_CONTROL)) icon_q <= REG_WDATA;
            if (hit(`OFF_IRQ_FLAGS_TWO)) iflag_q <= REG_WDATA;
            if (wr_end) begin
                iflag_q[`IRQ_WRITE_DONE_BIT] <= 1'b1;
            end
        end
    end

    assign WRITE_DONE_IRQ = iflag_q[`IRQ_WRITE_DONE_BIT] &
                            ien_q[`IRQ_WRITE_DONE_BIT];

    // Register read mux; unlock port reads zero
    always_comb begin
        REG_RDATA = 8'h00;
        if (REG_RD) begin
            unique case (REG_ADDR)
                `OFF_IRQ_ENABLE_TWO:   REG_RDATA = ien_q;
                `OFF_IRQ_FLAGS_TWO:    REG_RDATA = iflag_q;
                `OFF_IRQ_PRIORITY_TWO: REG_RDATA = iprio_q;
                `OFF_NVM_CONTROL:      REG_RDATA = {sel_q, 2'b00, abort_q,
                                                    allow_q, wr_go_q,
                                                    rd_go_q};
                `OFF_NVM_DATA_BYTE:    REG_RDATA = data_q;
                `OFF_NVM_BYTE_ADDRESS: REG_RDATA = addr_q;
                `OFF_CORE_IRQ_CONTROL: REG_RDATA = icon_q;
                default:               REG_RDATA = 8'h00;
            endcase
        end
    end

    // Checks
    sequence unlock_s;
        unl_q == UNLOCK_OPEN;
    endsequence

    start_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr_start |-> unlock_s ##0 (allow_q && !pwrt_busy))
        else $error("write started without unlock");
    busy_bit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wst_q != WR_IDLE |-> wr_go_q)
        else $error("write start bit low during write");
    done_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr_end |=> !wr_go_q && iflag_q[`IRQ_WRITE_DONE_BIT])
        else $error("write end did not flag");
    write_len_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr_start |=> wr_go_q [*2] ##[0:1000] !wr_go_q)
        else $error("write length wrong");
    pwrt_block_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        pwrt_busy |-> !wr_start)
        else $error("write during power-up timer");
    read_next_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ctl_wr && REG_WDATA[0] && wst_q == WR_IDLE
        |=> data_q == mem[$past(addr_q)] && !rd_go_q)
        else $error("read data not ready");
    unlock_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        REG_ADDR == `OFF_NVM_UNLOCK_PORT |-> REG_RDATA == 8'h00)
        else $error("unlock port read nonzero");
    protect_ext_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        EXT_RD && CODE_PROTECT |=> EXT_RDATA == 8'h00 && EXT_DENIED)
        else $error("external read under protect");
    allow_por_a: assert property (@(posedge SYS_CLK)
        !POR_N |=> !allow_q)
        else $error("write allow not cleared");
endmodule

`default_nettype wire

/* logic/nvm_access_pkg.sv */
// Types shared by the data nonvolatile byte store access block.
// Assumes nothing beyond a SystemVerilog compiler.
package nvm_access_pkg;
    // Unlock sequence tracker, Gray coded along its path
    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_GOT1 = 2'b01,
        UNLOCK_OPEN = 2'b11
    } unlock_state_t;
    // Self-timed write engine, Gray coded along erase then program
    typedef enum logic [1:0] {
        WR_IDLE    = 2'b00,
        WR_ERASE   = 2'b01,
        WR_PROGRAM = 2'b11
    } write_state_t;
endpackage

/* logic/nvm_access_regs.svh */
// Register offsets, field positions, reset values and timing for the
// data nonvolatile byte store access block.
// Assumes a 12-bit special function register address space.
`ifndef NVM_ACCESS_REGS_SVH
`define NVM_ACCESS_REGS_SVH

`define OFF_IRQ_ENABLE_TWO   12'hFA0
`define OFF_IRQ_FLAGS_TWO    12'hFA1
`define OFF_IRQ_PRIORITY_TWO 12'hFA2
`define OFF_NVM_CONTROL      12'hFA6
`define OFF_NVM_UNLOCK_PORT  12'hFA7
`define OFF_NVM_DATA_BYTE    12'hFA8
`define OFF_NVM_BYTE_ADDRESS 12'hFA9
`define OFF_CORE_IRQ_CONTROL 12'hFF2

`define CTL_READ_START_BIT   0
`define CTL_WRITE_START_BIT  1
`define CTL_WRITE_ALLOW_BIT  2
`define CTL_WRITE_ABORT_BIT  3
`define CTL_CONFIG_SEL_BIT   6
`define CTL_PROG_SEL_BIT     7
`define IRQ_WRITE_DONE_BIT   4
`define GLOBAL_IRQ_BIT       7

`define RST_IRQ_ENABLE_TWO   8'h00
`define RST_IRQ_FLAGS_TWO    8'h00
`define RST_IRQ_PRIORITY_TWO 8'h1F

`define UNLOCK_FIRST         8'h55
`define UNLOCK_SECOND        8'hAA

`define CLK_PERIOD_NS        40
`define POWERUP_TIME_MS      72
`define POWERUP_CYCLES       ((`POWERUP_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define WRITE_TIME_CYCLES    200

`endif

/* tb/core_model.sv */
// Behavioural processor core issuing register writes and reads.
// Assumes the block takes REG_WR and samples REG_RD on rising SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_regs.svh"

module core_model (
    input  wire logic        SYS_CLK,
    output logic      [11:0] REG_ADDR,
    output logic             REG_WR,
    output logic             REG_RD,
    output logic      [7:0]  REG_WDATA,
    input  wire logic [7:0]  REG_RDATA
);
    // Bus idle at time zero
    initial begin
        REG_ADDR  = 12'h000;
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_WDATA = 8'h00;
    end

    // One access; released write data shows its inverse
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(negedge SYS_CLK);
        REG_ADDR  = a;
        REG_WR    = wr;
        REG_RD    = !wr;
        REG_WDATA = d;
        @(posedge SYS_CLK);
        q = REG_RDATA;
        @(negedge SYS_CLK);
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_WDATA = ~d;
    endtask

    // Unlock pair into the unlock port, then the start write
    task automatic start_write(input logic [7:0] first,
                               input logic [7:0] second,
                               input logic [7:0] ctl);
        logic [7:0] q;
        xfer(1'b1, `OFF_NVM_UNLOCK_PORT, first, q);
        xfer(1'b1, `OFF_NVM_UNLOCK_PORT, second, q);
        xfer(1'b1, `OFF_NVM_CONTROL, ctl, q);
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the data byte store access block.
// Assumes the core model drives the register side, the bench the rest.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_regs.svh"

module tb
    import nvm_access_pkg::*;
;
    logic        sys_clk = 1'b0;   // Core clock, 40 ns
    logic        rst_n;            // General reset
    logic        por_n;            // Power-on reset
    logic [11:0] reg_addr;         // Register side, from core model
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        code_protect;     // External port lock
    logic        ext_rd;           // External programming port
    logic        ext_wr;
    logic [7:0]  ext_addr;
    logic [7:0]  ext_wdata;
    logic [7:0]  ext_rdata;
    logic        ext_denied;
    logic        write_done_irq;   // Done flag and enable
    logic [7:0]  q;                // Last read value
    int          n;                // Poll counter
    int          fails = 0;
    int          tests_run = 0;

    // Clock generator
    always #20 sys_clk = ~sys_clk;

    // Short timer and write counts keep the run brief
    nvm_access #(.POWERUP_CYCLES(40), .WRITE_CYCLES(8)) dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .POR_N(por_n),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .CODE_PROTECT(code_protect), .EXT_RD(ext_rd), .EXT_WR(ext_wr),
        .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata),
        .EXT_RDATA(ext_rdata), .EXT_DENIED(ext_denied),
        .WRITE_DONE_IRQ(write_done_irq));

    // Processor core on the register side
    core_model core (
        .SYS_CLK(sys_clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));

    // Verdict and end of run
    task automatic close_out;
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Byte comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Register write
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        core.xfer(1'b1, a, d, q);
    endtask

    // Register read and compare
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        core.xfer(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask

    // Control register low bits: allow, start, read
    task automatic cchk(input logic [2:0] exp);
        core.xfer(1'b0, `OFF_NVM_CONTROL, 8'h00, q);
        chk({5'h00, q[2:0]}, {5'h00, exp});
    endtask

    // Array byte read through address, read start and data register
    task automatic rd_byte(input logic [7:0] a, input logic [7:0] exp);
        wr(`OFF_NVM_BYTE_ADDRESS, a);
        wr(`OFF_NVM_CONTROL, 8'h05);
        rchk(`OFF_NVM_DATA_BYTE, exp);
    endtask

    // External port pulse; outputs settled at the following negedge
    task automatic ext(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge sys_clk);
        ext_rd    = !w;
        ext_wr    = w;
        ext_addr  = a;
        ext_wdata = d;
        @(negedge sys_clk);
        ext_rd    = 1'b0;
        ext_wr    = 1'b0;
        ext_wdata = ~d;
    endtask

    // Poll write start until it drops, bounded
    task automatic wait_done;
        for (n = 0; n < 20; n++) begin
            core.xfer(1'b0, `OFF_NVM_CONTROL, 8'h00, q);
            if (q[`CTL_WRITE_START_BIT] === 1'b0) break;
        end
        if (n == 20) begin
            fails++;
            $display("BAD %0t write did not finish", $time);
            close_out();
        end
    endtask

    // Main sequence
    initial begin
        rst_n        = 1'b0;
        por_n        = 1'b0;
        code_protect = 1'b0;
        ext_rd       = 1'b0;
        ext_wr       = 1'b0;
        ext_addr     = 8'h00;
        ext_wdata    = 8'h00;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        por_n = 1'b1;
        rchk(`OFF_IRQ_ENABLE_TWO, `RST_IRQ_ENABLE_TWO);
        rchk(`OFF_IRQ_FLAGS_TWO, `RST_IRQ_FLAGS_TWO);
        rchk(`OFF_IRQ_PRIORITY_TWO, `RST_IRQ_PRIORITY_TWO);
        rchk(`OFF_NVM_DATA_BYTE, 8'h00);
        rchk(`OFF_NVM_BYTE_ADDRESS, 8'h00);
        cchk(3'b000);
        wr(`OFF_NVM_UNLOCK_PORT, 8'h5A);
        rchk(`OFF_NVM_UNLOCK_PORT, 8'h00);
        // Correct sequence while the power-up timer runs
        wr(`OFF_NVM_CONTROL, 8'h04);
        core.start_write(`UNLOCK_FIRST, `UNLOCK_SECOND, 8'h06);
        cchk(3'b100);
        repeat (40) @(negedge sys_clk);
        // Allow and start in one write
        wr(`OFF_NVM_CONTROL, 8'h00);
        core.start_write(`UNLOCK_FIRST, `UNLOCK_SECOND, 8'h06);
        cchk(3'b100);
        // Unlock values swapped
        core.start_write(`UNLOCK_SECOND, `UNLOCK_FIRST, 8'h06);
        cchk(3'b100);
        // Good write to the top address, clear attempt mid-write
        wr(`OFF_NVM_BYTE_ADDRESS, 8'hFF);
        wr(`OFF_NVM_DATA_BYTE, 8'h3C);
        core.start_write(`UNLOCK_FIRST, `UNLOCK_SECOND, 8'h06);
        cchk(3'b110);
        wr(`OFF_NVM_CONTROL, 8'h04);
        cchk(3'b110);
        wait_done();
        cchk(3'b100);
        rchk(`OFF_IRQ_FLAGS_TWO, 8'h10);
        chk({7'h00, write_done_irq}, 8'h00);
        wr(`OFF_IRQ_ENABLE_TWO, 8'h10);
        chk({7'h00, write_done_irq}, 8'h01);
        wr(`OFF_IRQ_FLAGS_TWO, 8'h00);
        chk({7'h00, write_done_irq}, 8'h00);
        // Read back, byte held over a second read
        wr(`OFF_NVM_DATA_BYTE, 8'h00);
        rd_byte(8'hFF, 8'h3C);
        rchk(`OFF_NVM_DATA_BYTE, 8'h3C);
        // Core write and reads with the external port locked
        code_protect = 1'b1;
        wr(`OFF_NVM_BYTE_ADDRESS, 8'h00);
        wr(`OFF_NVM_DATA_BYTE, 8'hC3);
        core.start_write(`UNLOCK_FIRST, `UNLOCK_SECOND, 8'h06);
        wait_done();
        rd_byte(8'hFF, 8'h3C);
        rd_byte(8'h00, 8'hC3);
        ext(1'b0, 8'hFF, 8'h00);
        chk({7'h00, ext_denied}, 8'h01);
        chk(ext_rdata, 8'h00);
        ext(1'b1, 8'hFF, 8'h99);
        chk({7'h00, ext_denied}, 8'h01);
        rd_byte(8'hFF, 8'h3C);
        code_protect = 1'b0;
        ext(1'b0, 8'hFF, 8'h00);
        chk(ext_rdata, 8'h3C);
        chk({7'h00, ext_denied}, 8'h00);
        ext(1'b1, 8'h01, 8'h5A);
        rd_byte(8'h01, 8'h5A);
        // Reset in mid-write stops it and leaves the abort flag
        core.start_write(`UNLOCK_FIRST, `UNLOCK_SECOND, 8'h06);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        rchk(`OFF_NVM_CONTROL, 8'h08);
        rchk(`OFF_NVM_BYTE_ADDRESS, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
